//--- bpbt_bus_side.sv
// bpbt_bus_side: bus logic on the a and b ports
// assumes: each device pin split into in, out and oe
`timescale 1ns/1ps
module bpbt_bus_side (
    input  wire logic        clk_i,
    input  wire logic [17:0] a_val_i,
    input  wire logic [17:0] b_val_i,
    input  wire logic        a_float_i,
    input  wire logic [17:0] a_dev_i,
    input  wire logic [17:0] a_oe_i,
    input  wire logic [17:0] b_dev_i,
    input  wire logic [17:0] b_oe_i,
    output logic      [17:0] a_pin_o,
    output logic      [17:0] b_pin_o
);
    logic [17:0] junk = 18'h2AAAA;
    logic [17:0] a_drv;
    always @(posedge clk_i) begin
        junk <= ~junk;
    end
    assign a_drv   = a_float_i ? {junk[17:16], a_val_i[15:0]} : a_val_i;
    assign a_pin_o = (a_dev_i & a_oe_i) | (a_drv & ~a_oe_i);
    assign b_pin_o = (b_dev_i & b_oe_i) | (b_val_i & ~b_oe_i);
endmodule

//--- bpbt_dir_path.sv
// bpbt_dir_path: one transfer direction, buffer/latch/register plus parity
// assumes: synchronised inputs and a one-cycle capture pulse on the same clock
`timescale 1ns/1ps
module bpbt_dir_path (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire bpbt_pkg::bpbt_word_type in_i,
    input  wire bpbt_pkg::bpbt_mode_type mode_i,
    input  wire logic                   latch_en_i,
    input  wire logic                   cap_i,
    input  wire logic                   gen_i,
    input  wire logic                   odd_i,
    output bpbt_pkg::bpbt_word_type      out_o,
    output logic                        err_o
);
    bpbt_pkg::bpbt_word_type hold_reg;
    bpbt_pkg::bpbt_word_type hold_next;
    bpbt_pkg::bpbt_word_type sel_word;
    logic                    load;
    logic [1:0]              bad;
    logic [1:0]              gen_par;

    // ************************************************
    // storage
    // ************************************************
    // latch follow, register capture
    assign load = ((mode_i == bpbt_pkg::BPBT_MODE_LATCH) && latch_en_i) ||
                  ((mode_i == bpbt_pkg::BPBT_MODE_REG) && cap_i);
    assign hold_next = load ? in_i : hold_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_reg <= '0;
        end else begin
            hold_reg <= hold_next;
        end
    end

    always_comb begin
        unique case (mode_i)
            bpbt_pkg::BPBT_MODE_LATCH: sel_word = latch_en_i ? in_i : hold_reg;
            bpbt_pkg::BPBT_MODE_REG:   sel_word = hold_reg;
            bpbt_pkg::BPBT_MODE_BUF:   sel_word = in_i;
            default:                   sel_word = in_i;
        endcase
    end

    // ************************************************
    // parity
    // ************************************************
    // per-byte parity, mode independent
    assign gen_par[0] = bpbt_pkg::par_gen(sel_word.data[7:0], odd_i);
    assign gen_par[1] = bpbt_pkg::par_gen(sel_word.data[15:8], odd_i);
    assign bad[0]     = bpbt_pkg::par_bad(sel_word.data[7:0], sel_word.par[0], odd_i);
    assign bad[1]     = bpbt_pkg::par_bad(sel_word.data[15:8], sel_word.par[1], odd_i);
    assign out_o      = {(gen_i ? gen_par : sel_word.par), sel_word.data};
    assign err_o      = ~gen_i & (|bad);

    AST_GEN_PAR: assert property (@(posedge clk_i) disable iff (rst_i)
        gen_i |-> (out_o.par[1] == ((^out_o.data[15:8]) ^ odd_i)) && !err_o)
        else $error("generated parity wrong");
    AST_PASS_BUF: assert property (@(posedge clk_i) disable iff (rst_i)
        (!gen_i && mode_i == bpbt_pkg::BPBT_MODE_BUF) |-> (out_o == in_i))
        else $error("buffer mode altered word");
    AST_REG_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_i == bpbt_pkg::BPBT_MODE_REG && cap_i) ##1 (mode_i == bpbt_pkg::BPBT_MODE_REG)
        |-> (out_o.data == $past(in_i.data)))
        else $error("register mode missed capture");
    AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_i == bpbt_pkg::BPBT_MODE_LATCH && latch_en_i) ##1
        (mode_i == bpbt_pkg::BPBT_MODE_LATCH && !latch_en_i) |-> (out_o.data == $past(in_i.data)))
        else $error("latch did not hold last value");
    AST_CHECK_ERR: assert property (@(posedge clk_i) disable iff (rst_i)
        (!gen_i && ((^{out_o.data[7:0], out_o.par[0]}) != odd_i)) |-> err_o)
        else $error("bad low byte parity not flagged");
endmodule

//--- bpbt_pin_sync.sv
// bpbt_pin_sync: three-stage pin synchroniser with agreement filter
// assumes: asynchronous pin levels, one clock, synchronous reset
`timescale 1ns/1ps
module bpbt_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] level_next;

    // take a bit only once stages two and three agree
    assign level_next = (~(s2_reg ^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & level_reg);
    assign level_o    = level_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            level_reg <= '0;
        end else begin
            s1_reg    <= pin_i;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end

    AST_SYNC_AGREE: assert property (@(posedge clk_i) disable iff (rst_i)
        (s2_reg == s3_reg) |=> (level_reg == $past(s2_reg)))
        else $error("sync level did not follow agreeing stages");
endmodule

//--- bpbt_pkg.sv
// bpbt_pkg: shared types, register map and reset values of the parity transceiver
// assumes: a 32-bit classic wishbone slave and one 125 MHz clock
package bpbt_pkg;

    // ************************************************
    // widths and timing
    // ************************************************
    localparam int          DATA_W      = 16;
    localparam int          PAR_W       = 2;
    localparam int          PORT_W      = DATA_W + PAR_W;
    localparam int          SYNC_STAGES = 3;
    localparam int          CLK_PERIOD_NS = 8;

    // ************************************************
    // register map
    // ************************************************
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  STATUS_OFS  = 8'h04;
    localparam logic [7:0]  MASK_OFS    = 8'h08;
    localparam logic [7:0]  LIVE_OFS    = 8'h0C;
    localparam int          CTRL_W      = 10;
    localparam int          EVT_W       = 2;
    localparam int          EVT_AB_POS  = 0;
    localparam int          EVT_BA_POS  = 1;

    // ************************************************
    // types
    // ************************************************
    typedef enum logic [2:0] {
        BPBT_MODE_BUF   = 3'h1,
        BPBT_MODE_LATCH = 3'h2,
        BPBT_MODE_REG   = 3'h4
    } bpbt_mode_type;

    typedef struct packed {
        logic          b_to_a_output_enable_n;
        logic          a_to_b_output_enable_n;
        bpbt_mode_type ba_mode;
        bpbt_mode_type ab_mode;
        logic          odd_sel;
        logic          check_both;
    } bpbt_ctrl_type;

    typedef struct packed {
        logic [PAR_W-1:0]  par;
        logic [DATA_W-1:0] data;
    } bpbt_word_type;

    localparam bpbt_ctrl_type CTRL_RST = '{
        b_to_a_output_enable_n : 1'b1,
        a_to_b_output_enable_n : 1'b1,
        ba_mode                : BPBT_MODE_BUF,
        ab_mode                : BPBT_MODE_BUF,
        odd_sel                : 1'b0,
        check_both             : 1'b1
    };
    localparam logic [EVT_W-1:0] MASK_RST = 2'h0;

    // ************************************************
    // functions
    // ************************************************
    // parity bit that makes a byte even (odd_sel low) or odd (odd_sel high)
    function automatic logic par_gen(input logic [7:0] byte_v, input logic odd_sel);
        par_gen = (^byte_v) ^ odd_sel;
    endfunction

    // high when byte and its parity bit miss the selected sense
    function automatic logic par_bad(input logic [7:0] byte_v, input logic par_v, input logic odd_sel);
        par_bad = (^{byte_v, par_v}) ^ odd_sel;
    endfunction

endpackage

//--- bpbt_xcvr.sv
// bpbt_xcvr: 18-bit two-port parity transceiver with wishbone control
// assumes: pins arrive asynchronously, open-drain flags pulled up outside
`timescale 1ns/1ps
module bpbt_xcvr (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    output logic                             irq_o,
    input  wire logic [bpbt_pkg::DATA_W-1:0] a_data_i,
    output logic      [bpbt_pkg::DATA_W-1:0] a_data_o,
    output logic                             a_data_oe_o,
    input  wire logic                        a_side_parity_low_byte_i,
    output logic                             a_side_parity_low_byte_o,
    output logic                             a_side_parity_low_byte_oe_o,
    input  wire logic                        a_side_parity_high_byte_i,
    output logic                             a_side_parity_high_byte_o,
    output logic                             a_side_parity_high_byte_oe_o,
    input  wire logic [bpbt_pkg::DATA_W-1:0] b_data_i,
    output logic      [bpbt_pkg::DATA_W-1:0] b_data_o,
    output logic                             b_data_oe_o,
    input  wire logic [bpbt_pkg::PAR_W-1:0]  b_par_i,
    output logic      [bpbt_pkg::PAR_W-1:0]  b_par_o,
    output logic                             b_par_oe_o,
    input  wire logic                        ab_latch_en_i,
    input  wire logic                        ab_cap_clk_i,
    input  wire logic                        ba_latch_en_i,
    input  wire logic                        ba_cap_clk_i,
    output logic                             ab_parity_fault_flag_n_o,
    output logic                             ab_parity_fault_flag_n_oe_o,
    output logic                             ba_parity_fault_flag_n_o,
    output logic                             ba_parity_fault_flag_n_oe_o
);
    localparam int PIN_W = 2 * bpbt_pkg::PORT_W + 4;

    bpbt_pkg::bpbt_ctrl_type     ctrl_reg;
    bpbt_pkg::bpbt_ctrl_type     ctrl_next;
    logic [bpbt_pkg::EVT_W-1:0]  status_reg;
    logic [bpbt_pkg::EVT_W-1:0]  status_next;
    logic [bpbt_pkg::EVT_W-1:0]  mask_reg;
    logic [bpbt_pkg::EVT_W-1:0]  mask_next;
    logic [bpbt_pkg::EVT_W-1:0]  err_prev_reg;
    logic [bpbt_pkg::EVT_W-1:0]  err_now;
    logic [bpbt_pkg::EVT_W-1:0]  evt_set;
    logic [bpbt_pkg::EVT_W-1:0]  status_clr;
    logic [31:0]                 rd_mux;
    logic [31:0]                 wr_mask;
    logic [31:0]                 ctrl_wr;
    logic [31:0]                 dat_reg;
    logic                        ack_reg;
    logic                        wb_req;
    logic                        wr_ctrl;
    logic                        wr_mask_hit;
    logic                        rd_status;
    logic [PIN_W-1:0]            pin_raw;
    logic [PIN_W-1:0]            pin_sync;
    bpbt_pkg::bpbt_word_type     a_in_raw;
    bpbt_pkg::bpbt_word_type     a_in;
    bpbt_pkg::bpbt_word_type     b_in;
    bpbt_pkg::bpbt_word_type     ab_out;
    bpbt_pkg::bpbt_word_type     ba_out;
    logic                        ab_le;
    logic                        ba_le;
    logic                        ab_clk_lvl;
    logic                        ba_clk_lvl;
    logic                        ab_clk_prev_reg;
    logic                        ba_clk_prev_reg;
    logic                        ab_cap;
    logic                        ba_cap;
    logic                        gen_mode;
    logic                        ab_err;
    logic                        ba_err;

    // ************************************************
    // pin synchronisers
    // ************************************************
    assign pin_raw = {ab_latch_en_i, ab_cap_clk_i, ba_latch_en_i, ba_cap_clk_i,
                      b_par_i, b_data_i,
                      a_side_parity_high_byte_i, a_side_parity_low_byte_i, a_data_i};

    bpbt_pin_sync #(
        .W       (PIN_W)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (pin_raw),
        .level_o (pin_sync)
    );

    // two bytes plus two parity bits
    assign a_in_raw   = pin_sync[bpbt_pkg::PORT_W-1:0];
    assign b_in       = pin_sync[2*bpbt_pkg::PORT_W-1:bpbt_pkg::PORT_W];
    assign {ab_le, ab_clk_lvl, ba_le, ba_clk_lvl} = pin_sync[PIN_W-1:2*bpbt_pkg::PORT_W];
    assign ab_cap     = ab_clk_lvl & ~ab_clk_prev_reg;
    assign ba_cap     = ba_clk_lvl & ~ba_clk_prev_reg;

    // ************************************************
    // direction paths
    // ************************************************
    // generate a-to-b only when check_both is low
    assign gen_mode   = ~ctrl_reg.check_both;
    // a-side parity inputs dropped in generate mode
    assign a_in       = {(gen_mode ? 2'h0 : a_in_raw.par), a_in_raw.data};

    bpbt_dir_path u_ab_path (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .in_i       (a_in),
        .mode_i     (ctrl_reg.ab_mode),
        .latch_en_i (ab_le),
        .cap_i      (ab_cap),
        .gen_i      (gen_mode),
        .odd_i      (ctrl_reg.odd_sel),
        .out_o      (ab_out),
        .err_o      (ab_err)
    );

    bpbt_dir_path u_ba_path (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .in_i       (b_in),
        .mode_i     (ctrl_reg.ba_mode),
        .latch_en_i (ba_le),
        .cap_i      (ba_cap),
        .gen_i      (1'b0),
        .odd_i      (ctrl_reg.odd_sel),
        .out_o      (ba_out),
        .err_o      (ba_err)
    );

    // ************************************************
    // pin drivers
    // ************************************************
    assign b_data_o                     = ab_out.data;
    assign b_par_o                      = ab_out.par;
    assign b_data_oe_o                  = ~ctrl_reg.a_to_b_output_enable_n;
    assign b_par_oe_o                   = ~ctrl_reg.a_to_b_output_enable_n;
    assign a_data_o                     = ba_out.data;
    assign a_side_parity_low_byte_o     = ba_out.par[0];
    assign a_side_parity_high_byte_o    = ba_out.par[1];
    assign a_data_oe_o                  = ~ctrl_reg.b_to_a_output_enable_n;
    assign a_side_parity_low_byte_oe_o  = ~ctrl_reg.b_to_a_output_enable_n;
    assign a_side_parity_high_byte_oe_o = ~ctrl_reg.b_to_a_output_enable_n;
    // open-drain flags pull low on error
    assign ab_parity_fault_flag_n_o     = 1'b0;
    assign ab_parity_fault_flag_n_oe_o  = ab_err;
    assign ba_parity_fault_flag_n_o     = 1'b0;
    assign ba_parity_fault_flag_n_oe_o  = ba_err;

    // ************************************************
    // wishbone slave
    // ************************************************
    assign wb_req      = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_ctrl     = wb_req & wb_we_i & (wb_adr_i == bpbt_pkg::CTRL_OFS);
    assign wr_mask_hit = wb_req & wb_we_i & (wb_adr_i == bpbt_pkg::MASK_OFS);
    assign rd_status   = wb_req & ~wb_we_i & (wb_adr_i == bpbt_pkg::STATUS_OFS);
    assign wr_mask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign ctrl_wr     = (wb_dat_i & wr_mask) | ({22'h000000, ctrl_reg} & ~wr_mask);
    assign ctrl_next   = wr_ctrl ? bpbt_pkg::bpbt_ctrl_type'(ctrl_wr[bpbt_pkg::CTRL_W-1:0]) : ctrl_reg;
    assign mask_next   = (wr_mask_hit && wb_sel_i[0]) ? wb_dat_i[bpbt_pkg::EVT_W-1:0] : mask_reg;
    assign rd_mux      = (wb_adr_i == bpbt_pkg::CTRL_OFS)   ? {22'h000000, ctrl_reg}   :
                         (wb_adr_i == bpbt_pkg::STATUS_OFS) ? {30'h00000000, status_reg} :
                         (wb_adr_i == bpbt_pkg::MASK_OFS)   ? {30'h00000000, mask_reg}   :
                         (wb_adr_i == bpbt_pkg::LIVE_OFS)   ? {30'h00000000, err_now}    : 32'h00000000;
    assign wb_ack_o    = ack_reg;
    assign wb_dat_o    = dat_reg;

    // ************************************************
    // interrupt status
    // ************************************************
    assign err_now     = {ba_err, ab_err};
    assign evt_set     = err_now & ~err_prev_reg;
    assign status_clr  = rd_status ? status_reg : '0;
    assign status_next = (status_reg & ~status_clr) | evt_set;
    assign irq_o       = |(status_reg & mask_reg);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg        <= bpbt_pkg::CTRL_RST;
            mask_reg        <= bpbt_pkg::MASK_RST;
            status_reg      <= '0;
            err_prev_reg    <= '0;
            ack_reg         <= 1'b0;
            dat_reg         <= 32'h00000000;
            ab_clk_prev_reg <= 1'b0;
            ba_clk_prev_reg <= 1'b0;
        end else begin
            ctrl_reg        <= ctrl_next;
            mask_reg        <= mask_next;
            status_reg      <= status_next;
            err_prev_reg    <= err_now;
            ack_reg         <= wb_req;
            dat_reg         <= wb_req ? rd_mux : dat_reg;
            ab_clk_prev_reg <= ab_clk_lvl;
            ba_clk_prev_reg <= ba_clk_lvl;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    sequence seq_rd_status;
        wb_req && !wb_we_i && (wb_adr_i == bpbt_pkg::STATUS_OFS);
    endsequence

    sequence seq_err_rise;
        ab_err && !err_prev_reg[bpbt_pkg::EVT_AB_POS];
    endsequence

    sequence seq_ba_err_rise;
        ba_err && !err_prev_reg[bpbt_pkg::EVT_BA_POS];
    endsequence

    sequence seq_wr_ctrl;
        wr_ctrl && (wb_sel_i == 4'hF);
    endsequence

    sequence seq_wr_mask;
        wr_mask_hit && wb_sel_i[0];
    endsequence

    AST_FLAG_OD: assert property (@(posedge clk_i) disable iff (rst_i)
        (ab_parity_fault_flag_n_o == 1'b0) && (ab_parity_fault_flag_n_oe_o == ab_err) &&
        (ba_parity_fault_flag_n_oe_o == ba_err))
        else $error("fault flag not open drain");
    AST_GEN_A_PARITY_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_reg.check_both |-> !ab_err && (b_par_o[0] == ((^b_data_o[7:0]) ^ ctrl_reg.odd_sel)))
        else $error("generate mode used a-side parity pins");
    AST_STICKY_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_err_rise |=> status_reg[bpbt_pkg::EVT_AB_POS])
        else $error("error event not latched");
    AST_READ_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_rd_status and (evt_set == 2'h0)) |=> (status_reg == 2'h0) && wb_ack_o)
        else $error("status read did not clear");
    AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
        (status_reg[bpbt_pkg::EVT_BA_POS] && mask_reg[bpbt_pkg::EVT_BA_POS]) |-> irq_o)
        else $error("interrupt missing for unmasked status");
    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle");
    AST_CAP_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
        ab_cap |=> !ab_cap)
        else $error("capture pulse longer than one cycle");
    AST_BA_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_ba_err_rise |=> status_reg[bpbt_pkg::EVT_BA_POS])
        else $error("b-to-a error event not latched");
    AST_CTRL_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_wr_ctrl |=> (ctrl_reg == bpbt_pkg::bpbt_ctrl_type'($past(wb_dat_i[bpbt_pkg::CTRL_W-1:0]))))
        else $error("control write not applied");
    AST_MASK_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_wr_mask |=> (mask_reg == $past(wb_dat_i[bpbt_pkg::EVT_W-1:0])))
        else $error("mask write not applied");
    AST_A_OE_MATCH: assert property (@(posedge clk_i) disable iff (rst_i)
        (a_side_parity_low_byte_oe_o == a_data_oe_o) && (a_side_parity_high_byte_oe_o == a_data_oe_o))
        else $error("a-side parity enable differs from data");
    AST_B_OE_MATCH: assert property (@(posedge clk_i) disable iff (rst_i)
        (b_par_oe_o == b_data_oe_o) && (b_data_oe_o == !ctrl_reg.a_to_b_output_enable_n))
        else $error("b-side enables disagree");
    AST_PASS_PARITY: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_reg.check_both && (ctrl_reg.ab_mode == bpbt_pkg::BPBT_MODE_BUF)) |-> (b_par_o == a_in.par))
        else $error("checked parity not passed through");
    AST_GEN_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_reg.check_both |-> (b_par_o[1] == ((^b_data_o[15:8]) ^ ctrl_reg.odd_sel)))
        else $error("high byte parity not generated");
    AST_A_PAR_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
        gen_mode |-> (a_in.par == 2'h0))
        else $error("a-side parity inputs used in generate mode");
    AST_IRQ_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        ((status_reg & mask_reg) == 2'h0) |-> !irq_o)
        else $error("interrupt without unmasked status");
    AST_DAT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_req |=> $stable(wb_dat_o))
        else $error("read data changed without request");
endmodule

//--- byte_parity_bus_transceiver_tb.sv
// byte_parity_bus_transceiver_tb: random and corner tests of bpbt_xcvr
// assumes: bpbt_pkg, bpbt_xcvr and bpbt_bus_side compiled first
`timescale 1ns/1ps
module byte_parity_bus_transceiver_tb;
    logic        clk, rst, cyc, stb, we, ab_le, ab_cap, ba_le, ba_cap, a_float;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat, q;
    logic [17:0] a_val, b_val;
    wire  [31:0] rdat;
    wire  [17:0] a_pin, b_pin, a_dev, b_dev, a_oe, b_oe;
    wire         ack, irq, aoe, boe, bpoe, ab_f, ab_foe, ba_f, ba_foe;
    int          n_fail, checked, cyc_n;
    assign a_oe[15:0] = {16{aoe}};
    assign b_oe = {{2{bpoe}}, {16{boe}}};
    bpbt_xcvr i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .a_data_i(a_pin[15:0]), .a_data_o(a_dev[15:0]), .a_data_oe_o(aoe),
        .a_side_parity_low_byte_i(a_pin[16]), .a_side_parity_low_byte_o(a_dev[16]),
        .a_side_parity_low_byte_oe_o(a_oe[16]), .a_side_parity_high_byte_i(a_pin[17]),
        .a_side_parity_high_byte_o(a_dev[17]), .a_side_parity_high_byte_oe_o(a_oe[17]),
        .b_data_i(b_pin[15:0]), .b_data_o(b_dev[15:0]), .b_data_oe_o(boe), .b_par_i(b_pin[17:16]),
        .b_par_o(b_dev[17:16]), .b_par_oe_o(bpoe), .ab_latch_en_i(ab_le), .ab_cap_clk_i(ab_cap),
        .ba_latch_en_i(ba_le), .ba_cap_clk_i(ba_cap), .ab_parity_fault_flag_n_o(ab_f),
        .ab_parity_fault_flag_n_oe_o(ab_foe), .ba_parity_fault_flag_n_o(ba_f),
        .ba_parity_fault_flag_n_oe_o(ba_foe));
    bpbt_bus_side i_side (.clk_i(clk), .a_val_i(a_val), .b_val_i(b_val), .a_float_i(a_float),
        .a_dev_i(a_dev), .a_oe_i(a_oe), .b_dev_i(b_dev), .b_oe_i(b_oe), .a_pin_o(a_pin), .b_pin_o(b_pin));
    // ************************************************
    // helpers
    // ************************************************
    function automatic logic [1:0] pgen(input logic [15:0] d, input logic odd);
        pgen = {^d[15:8] ^ odd, ^d[7:0] ^ odd};
    endfunction
    function automatic logic parity_fault_flag_n(input logic [17:0] w, input logic odd);
        parity_fault_flag_n = (^{w[7:0], w[16]} ^ odd) | (^{w[15:8], w[17]} ^ odd);
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic step(input logic dir, input logic [2:0] md, input logic gen, input logic odd);
        logic [31:0] w;
        logic [17:0] e;
        logic [2:0]  r;
        w = $urandom;
        r = {md[1:0], md[2]};
        a_float <= gen;
        wb(1'b1, bpbt_pkg::CTRL_OFS, {22'h0, ~dir, dir, dir ? md : r, dir ? r : md, odd, ~gen});
        if (dir) b_val <= w[17:0]; else a_val <= w[17:0];
        ab_le <= 1'b1; ba_le <= 1'b1; ab_cap <= 1'b1; ba_cap <= 1'b1;
        wt(6);
        ab_le <= 1'b0; ba_le <= 1'b0; ab_cap <= 1'b0; ba_cap <= 1'b0;
        wt(6);
        if (md != 3'h1) begin
            if (dir) b_val <= ~w[17:0]; else a_val <= ~w[17:0];
            wt(6);
        end
        e = gen ? {pgen(w[15:0], odd), w[15:0]} : w[17:0];
        if (dir) begin
            chk("a_side", a_dev, e);
            chk("a_oe", a_oe, 18'h3FFFF);
            chk("ba_flag", {ba_f, ba_foe}, {1'b0, parity_fault_flag_n(w[17:0], odd)});
        end else begin
            chk("b_side", b_dev, e);
            chk("b_oe", b_oe, 18'h3FFFF);
            chk("ab_flag", {ab_f, ab_foe}, {1'b0, ~gen & parity_fault_flag_n(w[17:0], odd)});
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ************************************************
    // clock, timeout, sequence
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        {cyc, stb, we, ab_le, ab_cap, ba_le, ba_cap, a_float, adr, dat, a_val, b_val} = '0;
        {n_fail, checked, cyc_n} = '0;
        sel = 4'hF;
        rst = 1'b1;
        wt(8);
        rst <= 1'b0;
        wt(1);
        void'($urandom(32'hC18E31C4));
        wb(1'b0, bpbt_pkg::CTRL_OFS, '0);
        chk("ctrl_rst", q, 32'(bpbt_pkg::CTRL_RST));
        wb(1'b1, 8'h40, 32'hFFFFFFFF);
        wb(1'b0, 8'h40, '0);
        chk("unmapped", q, '0);
        wb(1'b1, bpbt_pkg::MASK_OFS, 32'h3);
        wb(1'b0, bpbt_pkg::MASK_OFS, '0);
        chk("mask", q, 32'h3);
        $display("test registers done");
        for (int i = 0; i < 52; i++) begin
            q = $urandom;
            if (i < 12) step(i[0], 3'h1 << (i / 2 % 3), ~i[0] & i[2], i[3]);
            else step(q[0], 3'h1 << (q[2:1] % 3), ~q[0] & q[3], q[4]);
        end
        $display("test data paths done");
        wb(1'b1, bpbt_pkg::CTRL_OFS, 32'h225);
        a_val <= '0;
        a_float <= 1'b0;
        wt(16);
        wb(1'b0, bpbt_pkg::STATUS_OFS, '0);
        chk("irq_clear", irq, 1'b0);
        a_val <= 18'h10000;
        wt(8);
        chk("irq_set", irq, 1'b1);
        wb(1'b1, bpbt_pkg::MASK_OFS, '0);
        chk("irq_masked", irq, 1'b0);
        wb(1'b1, bpbt_pkg::MASK_OFS, 32'h3);
        wb(1'b0, bpbt_pkg::LIVE_OFS, '0);
        chk("live", q, 32'h3);
        wb(1'b0, bpbt_pkg::STATUS_OFS, '0);
        chk("status", q, 32'h3);
        chk("irq_read", irq, 1'b0);
        wb(1'b1, bpbt_pkg::STATUS_OFS, 32'h3);
        wb(1'b0, bpbt_pkg::STATUS_OFS, '0);
        chk("status_ro", q, '0);
        $display("test interrupt done");
        results();
    end
endmodule
